/* pdgem_consts.svh */
`ifndef PDGEM_CONSTS_SVH
`define PDGEM_CONSTS_SVH

// ==========================================
// event numbers
`define PDGEM_EV_WIDTH 8
`define PDGEM_EV_NULL 8'h00
`define PDGEM_EV_CHG_PG_WAIT 8'h9e
`define PDGEM_EV_LIQ_DET 8'h9d
`define PDGEM_EV_LIQ_NMOS 8'h9c
`define PDGEM_EV_LIQ_PMOS 8'h9b
`define PDGEM_EV_NEG_ACTIVE 8'h4c
`define PDGEM_EV_SINK_ATTACH 8'h4b
`define PDGEM_EV_SRC_ROLE 8'h49
`define PDGEM_EV_LOAD_SW 8'h41
`define PDGEM_EV_USB2_MUX 8'h3d
`define PDGEM_EV_DEBUG_ACC 8'h32
`define PDGEM_EV_BLOCK_DRS 8'h2d
`define PDGEM_EV_UFP_IND 8'h2c
`define PDGEM_EV_WALL_ADP 8'h2b
`define PDGEM_EV_FAULT_N 8'h23

// ==========================================
// register map
`define PDGEM_ADDR_WIDTH 4
`define PDGEM_REG_EVSEL0 4'h0
`define PDGEM_REG_EVSEL1 4'h1
`define PDGEM_REG_EVSEL2 4'h2
`define PDGEM_REG_EVSEL3 4'h3
`define PDGEM_REG_PORT_CFG 4'h4
`define PDGEM_REG_SRC_INPUTS 4'h5
`define PDGEM_REG_PIN_STATE 4'h6
`define PDGEM_REG_STATUS 4'h7
`define PDGEM_PORT_CFG_UNLIM_BIT 0
`define PDGEM_SRC_IN_BIT0 0

// ==========================================
// timing and sizes
`define PDGEM_NUM_PINS 4
`define PDGEM_LIQ_TOGGLE_NS 1000
`define PDGEM_CLK_NS 25
`define PDGEM_LIQ_TOGGLE_CYC ((`PDGEM_LIQ_TOGGLE_NS) / (`PDGEM_CLK_NS))
`define PDGEM_TOG_CNT_WIDTH 6

`endif

/* pdgem_pkg.sv */
package pdgem_pkg;

   `include "pdgem_consts.svh"

   typedef logic [`PDGEM_EV_WIDTH-1:0] pdgem_ev_t;
   typedef logic [`PDGEM_ADDR_WIDTH-1:0] pdgem_addr_t;

   // ==========================================
   // negotiation tracker states
   typedef enum logic [2:0] {
      PDGEM_NEG_IDLE = 3'b001,
      PDGEM_NEG_SRC = 3'b010,
      PDGEM_NEG_SNK = 3'b100
   } pdgem_neg_e;

   // ==========================================
   // port state from the negotiation engine
   typedef struct packed {
      logic attached;
      logic any_port_on_source;
      logic is_source;
      logic is_ufp_any;
      logic debug_acc;
      logic ext_sink_path_en;
      logic overcurrent;
      logic liquid_detected;
      logic liquid_running;
      logic request_rx;
      logic request_tx_soon;
      logic ps_rdy_tx;
      logic ps_rdy_rx;
      logic detach;
      logic hard_reset;
      logic pr_swap;
      logic fr_swap;
   } pdgem_port_s;

   // ==========================================
   // decoded input events to the engine
   typedef struct packed {
      logic charger_power_good_wait;
      logic block_data_role_downgrade;
      logic wall_adapter_present;
      logic wall_rise;
      logic wall_fall;
   } pdgem_in_ev_s;

   // ==========================================
   // register bus request
   typedef struct packed {
      pdgem_addr_t addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pdgem_bus_s;

   // ==========================================
   // module state
   typedef struct packed {
      logic [`PDGEM_NUM_PINS-1:0] sync1;
      logic [`PDGEM_NUM_PINS-1:0] sync2;
      logic [`PDGEM_NUM_PINS-1:0] prev;
      logic [`PDGEM_NUM_PINS*`PDGEM_EV_WIDTH-1:0] evsel;
      pdgem_neg_e neg;
      logic neg_active;
      logic sink_attach;
      logic unlim;
      logic src_in0;
      logic liq_phase;
      logic [`PDGEM_TOG_CNT_WIDTH-1:0] tog_cnt;
      logic [`PDGEM_NUM_PINS-1:0] pin_out;
      logic [`PDGEM_NUM_PINS-1:0] pin_oe;
      pdgem_in_ev_s in_ev;
      logic [31:0] rdata;
      logic reject_drs;
      logic unlim_out;
      logic src_in0_out;
   } pdgem_state_s;

endpackage

/* pdgem_event_mapper.sv */
// Operation
// - input on event 158 means charger allows I2C in dead-battery start-up
// - event 157 output follows liquid detected on SBU pins
// - event 156 drives n-channel sensor switch, toggles during detection
// - event 155 drives p-channel sensor switch, toggles during detection
// - source mode: event 76 high from Request received until PS_RDY sent
// - sink mode: event 76 high from just before Request until PS_RDY received
// - event 76 drops on any detach
// - event 75 high while any port is connected to a source
// - event 75 drops on disconnect, resets, swaps only if no port on source
// - event 73 high whenever acting as power source
// - event 65 low while external sink path enabled
// - event 65 high while external sink path disabled
// - event 61 high on connect, low on disconnect
// - event 50 high while debug accessory attached
// - event 45 input high rejects DFP to UFP data-role swaps
// - event 44 high when any port is UFP
// - event 43 input high means barrel jack, unconstrained power
// - falling edge on event 43 clears power flag and source input bit 0
// - rising edge on event 43 sets power flag and source input bit 0
// - event 35 output driven low on overcurrent
`timescale 1ns/10ps
`include "pdgem_consts.svh"

module pdgem_event_mapper (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   // register port
   input wire pdgem_pkg::pdgem_addr_t addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // port state from negotiation engine
   input wire pdgem_pkg::pdgem_port_s port_in,
   // decoded input events to the engine
   output pdgem_pkg::pdgem_in_ev_s in_ev_out,
   output logic reject_dr_swap_out,
   output logic unlimited_power_flag_out,
   output logic source_input_bits0_out,
   // pins
   input wire logic [`PDGEM_NUM_PINS-1:0] gpio_in,
   output logic [`PDGEM_NUM_PINS-1:0] gpio_out,
   output logic [`PDGEM_NUM_PINS-1:0] gpio_oe_out
);
   import pdgem_pkg::*;

   localparam int NP = `PDGEM_NUM_PINS;
   localparam int EW = `PDGEM_EV_WIDTH;
   localparam int TOG_CYC = `PDGEM_LIQ_TOGGLE_CYC;

   pdgem_state_s s_q;
   pdgem_state_s s_d;

   // ==========================================
   // output value per event
   function automatic logic [1:0] ev_out(input pdgem_ev_t ev, input logic neg_act,
                                         input logic snk, input logic liq_ph,
                                         input pdgem_port_s p);
      logic [1:0] r;
      r = 2'b00;
      if (ev == `PDGEM_EV_LIQ_DET) begin
         r = {1'b1, p.liquid_detected};
      end else if (ev == `PDGEM_EV_LIQ_NMOS) begin
         r = {1'b1, p.liquid_running & liq_ph};
      end else if (ev == `PDGEM_EV_LIQ_PMOS) begin
         r = {1'b1, p.liquid_running & ~liq_ph};
      end else if (ev == `PDGEM_EV_NEG_ACTIVE) begin
         r = {1'b1, neg_act};
      end else if (ev == `PDGEM_EV_SINK_ATTACH) begin
         r = {1'b1, snk};
      end else if (ev == `PDGEM_EV_SRC_ROLE) begin
         r = {1'b1, p.is_source};
      end else if (ev == `PDGEM_EV_LOAD_SW) begin
         r = {1'b1, ~p.ext_sink_path_en};
      end else if (ev == `PDGEM_EV_USB2_MUX) begin
         r = {1'b1, p.attached};
      end else if (ev == `PDGEM_EV_DEBUG_ACC) begin
         r = {1'b1, p.debug_acc};
      end else if (ev == `PDGEM_EV_UFP_IND) begin
         r = {1'b1, p.is_ufp_any};
      end else if (ev == `PDGEM_EV_FAULT_N) begin
         r = {1'b1, ~p.overcurrent};
      end
      return r;
   endfunction

   // ==========================================
   // next state
   always_comb begin
      logic [1:0] o;
      logic [NP-1:0] rise;
      logic [NP-1:0] fall;
      pdgem_ev_t ev;
      o = 2'b00;
      rise = '0;
      fall = '0;
      ev = '0;
      s_d = s_q;
      s_d.sync1 = gpio_in;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
      rise = s_q.sync2 & ~s_q.prev;
      fall = ~s_q.sync2 & s_q.prev;
      // negotiation tracker
      case (s_q.neg)
         PDGEM_NEG_IDLE: begin
            if (port_in.is_source && port_in.request_rx) begin
               s_d.neg = PDGEM_NEG_SRC;
            end else if (!port_in.is_source && port_in.request_tx_soon) begin
               s_d.neg = PDGEM_NEG_SNK;
            end
         end
         PDGEM_NEG_SRC: begin
            if (port_in.ps_rdy_tx) begin
               s_d.neg = PDGEM_NEG_IDLE;
            end
         end
         PDGEM_NEG_SNK: begin
            if (port_in.ps_rdy_rx) begin
               s_d.neg = PDGEM_NEG_IDLE;
            end
         end
         default: begin
            s_d.neg = PDGEM_NEG_IDLE;
         end
      endcase
      if (port_in.detach) begin
         s_d.neg = PDGEM_NEG_IDLE;
      end
      s_d.neg_active = (s_d.neg != PDGEM_NEG_IDLE);
      // sink attach indicator
      if (port_in.any_port_on_source) begin
         s_d.sink_attach = 1'b1;
      end else if (port_in.detach || port_in.hard_reset || port_in.pr_swap
                   || port_in.fr_swap) begin
         s_d.sink_attach = 1'b0;
      end
      // liquid sensor toggle
      if (port_in.liquid_running) begin
         if (s_q.tog_cnt == '0) begin
            s_d.tog_cnt = `PDGEM_TOG_CNT_WIDTH'(TOG_CYC - 1);
            s_d.liq_phase = ~s_q.liq_phase;
         end else begin
            s_d.tog_cnt = s_q.tog_cnt - 1'b1;
         end
      end else begin
         s_d.tog_cnt = '0;
         s_d.liq_phase = 1'b0;
      end
      // input events and pin outputs
      s_d.in_ev = '0;
      s_d.in_ev.wall_adapter_present = s_q.in_ev.wall_adapter_present;
      for (int i = 0; i < NP; i++) begin
         ev = s_q.evsel[i*EW +: EW];
         o = ev_out(ev, s_q.neg_active, s_q.sink_attach, s_q.liq_phase, port_in);
         s_d.pin_oe[i] = o[1];
         s_d.pin_out[i] = o[0];
         if (ev == `PDGEM_EV_CHG_PG_WAIT && s_q.sync2[i]) begin
            s_d.in_ev.charger_power_good_wait = 1'b1;
         end
         if (ev == `PDGEM_EV_BLOCK_DRS && s_q.sync2[i]) begin
            s_d.in_ev.block_data_role_downgrade = 1'b1;
         end
         if (ev == `PDGEM_EV_WALL_ADP) begin
            s_d.in_ev.wall_adapter_present = s_q.sync2[i];
            if (rise[i]) begin
               s_d.in_ev.wall_rise = 1'b1;
            end
            if (fall[i]) begin
               s_d.in_ev.wall_fall = 1'b1;
            end
         end
      end
      s_d.reject_drs = s_d.in_ev.block_data_role_downgrade;
      // register port
      s_d.rdata = '0;
      if (wr_in) begin
         if (addr_in == `PDGEM_REG_EVSEL0) begin
            s_d.evsel[0*EW +: EW] = wdata_in[EW-1:0];
         end else if (addr_in == `PDGEM_REG_EVSEL1) begin
            s_d.evsel[1*EW +: EW] = wdata_in[EW-1:0];
         end else if (addr_in == `PDGEM_REG_EVSEL2) begin
            s_d.evsel[2*EW +: EW] = wdata_in[EW-1:0];
         end else if (addr_in == `PDGEM_REG_EVSEL3) begin
            s_d.evsel[3*EW +: EW] = wdata_in[EW-1:0];
         end else if (addr_in == `PDGEM_REG_PORT_CFG) begin
            s_d.unlim = wdata_in[`PDGEM_PORT_CFG_UNLIM_BIT];
         end else if (addr_in == `PDGEM_REG_SRC_INPUTS) begin
            s_d.src_in0 = wdata_in[`PDGEM_SRC_IN_BIT0];
         end
      end
      // edges win over a software write in the same cycle
      if (s_q.in_ev.wall_rise) begin
         s_d.unlim = 1'b1;
         s_d.src_in0 = 1'b1;
      end else if (s_q.in_ev.wall_fall) begin
         s_d.unlim = 1'b0;
         s_d.src_in0 = 1'b0;
      end
      s_d.unlim_out = s_d.unlim;
      s_d.src_in0_out = s_d.src_in0;
      if (rd_in) begin
         if (addr_in == `PDGEM_REG_EVSEL0) begin
            s_d.rdata = {24'h000000, s_q.evsel[0*EW +: EW]};
         end else if (addr_in == `PDGEM_REG_EVSEL1) begin
            s_d.rdata = {24'h000000, s_q.evsel[1*EW +: EW]};
         end else if (addr_in == `PDGEM_REG_EVSEL2) begin
            s_d.rdata = {24'h000000, s_q.evsel[2*EW +: EW]};
         end else if (addr_in == `PDGEM_REG_EVSEL3) begin
            s_d.rdata = {24'h000000, s_q.evsel[3*EW +: EW]};
         end else if (addr_in == `PDGEM_REG_PORT_CFG) begin
            s_d.rdata = {31'h00000000, s_q.unlim};
         end else if (addr_in == `PDGEM_REG_SRC_INPUTS) begin
            s_d.rdata = {31'h00000000, s_q.src_in0};
         end else if (addr_in == `PDGEM_REG_PIN_STATE) begin
            s_d.rdata = {20'h00000, s_q.pin_oe, s_q.pin_out, s_q.sync2};
         end else if (addr_in == `PDGEM_REG_STATUS) begin
            s_d.rdata = {26'h0000000, s_q.sink_attach, s_q.neg_active, s_q.liq_phase,
                         s_q.in_ev.charger_power_good_wait,
                         s_q.in_ev.block_data_role_downgrade,
                         s_q.in_ev.wall_adapter_present};
         end
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s_q <= '0;
         s_q.neg <= PDGEM_NEG_IDLE;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // outputs
   assign rdata_out = s_q.rdata;
   assign in_ev_out = s_q.in_ev;
   assign reject_dr_swap_out = s_q.reject_drs;
   assign unlimited_power_flag_out = s_q.unlim_out;
   assign source_input_bits0_out = s_q.src_in0_out;
   assign gpio_out = s_q.pin_out;
   assign gpio_oe_out = s_q.pin_oe;

endmodule

/* pdgem_event_mapper_sva.sv */
`timescale 1ns/10ps
`include "pdgem_consts.svh"
// ====
// checker
module pdgem_chk (
   // clock, reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // register port
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   // engine side
   input wire pdgem_pkg::pdgem_in_ev_s in_ev_out,
   input wire logic reject_dr_swap_out,
   input wire logic unlimited_power_flag_out,
   input wire logic source_input_bits0_out
);
   import pdgem_pkg::*;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   sequence s_up;
      in_ev_out.wall_rise ##1 (unlimited_power_flag_out && source_input_bits0_out);
   endsequence
   sequence s_dn;
      in_ev_out.wall_fall ##1 !(unlimited_power_flag_out || source_input_bits0_out);
   endsequence
   AST_WALL_UP: assert property ($rose(in_ev_out.wall_adapter_present) |-> s_up)
      else $error("wall rise did not set flags");
   AST_WALL_DN: assert property ($fell(in_ev_out.wall_adapter_present) |-> s_dn)
      else $error("wall fall did not clear flags");
   AST_PULSE_ONE: assert property ((in_ev_out.wall_rise || in_ev_out.wall_fall)
      |=> !(in_ev_out.wall_rise || in_ev_out.wall_fall)) else $error("edge pulse too long");
   AST_RISE_LVL: assert property (in_ev_out.wall_rise |-> in_ev_out.wall_adapter_present)
      else $error("rise pulse without level");
   AST_FALL_LVL: assert property (in_ev_out.wall_fall |-> !in_ev_out.wall_adapter_present)
      else $error("fall pulse with level");
   AST_BLOCK: assert property ($rose(in_ev_out.block_data_role_downgrade)
      |-> ##[0:2] reject_dr_swap_out) else $error("swap block not passed on");
   AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside its cycle");
   AST_FLAG_HOLD: assert property ($changed(unlimited_power_flag_out)
      |-> $past(in_ev_out.wall_rise || in_ev_out.wall_fall || wr_in))
      else $error("flag changed without cause");
endmodule

bind pdgem_event_mapper pdgem_chk u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .in_ev_out(in_ev_out),
   .reject_dr_swap_out(reject_dr_swap_out),
   .unlimited_power_flag_out(unlimited_power_flag_out),
   .source_input_bits0_out(source_input_bits0_out));

/* pdgem_sys_model.sv */
`timescale 1ns/10ps
`include "pdgem_consts.svh"
// ====
// system circuits on the pins
module pdgem_sys_model (
   // device pin drive
   input wire logic [`PDGEM_NUM_PINS-1:0] gpio_out,
   input wire logic [`PDGEM_NUM_PINS-1:0] gpio_oe_out,
   // level the system circuits drive
   input wire logic [`PDGEM_NUM_PINS-1:0] ext_lvl_in,
   // resolved wire
   output logic [`PDGEM_NUM_PINS-1:0] pin_lvl_out
);
   // driven pins win, released pins follow the system circuit
   assign pin_lvl_out = (gpio_oe_out & gpio_out) | (~gpio_oe_out & ext_lvl_in);
endmodule

/* tb_pd_gpio_event_mapper.sv */
`timescale 1ns/10ps
`include "pdgem_consts.svh"
module tb_pd_gpio_event_mapper;
   import pdgem_pkg::*;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   pdgem_addr_t addr_in = '0;
   logic [31:0] wdata_in = '0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   pdgem_port_s port_in = '0;
   logic [3:0] ext_lvl = '0;
   logic [31:0] rdata_out, e, m;
   pdgem_in_ev_s in_ev_out;
   logic rej, unlim, src0, a;
   logic [3:0] gpio_in, gpio_out, gpio_oe_out;
   logic [31:0] exp_q[$], msk_q[$];
   logic rd_seen = 1'b0;
   int error_cnt = 0, samples_checked = 0, seed = 33, rise_cnt = 0, fall_cnt = 0;
   string tname = "reset";
   pdgem_ev_t evs[7] = '{`PDGEM_EV_LIQ_DET, `PDGEM_EV_SRC_ROLE, `PDGEM_EV_LOAD_SW,
      `PDGEM_EV_USB2_MUX, `PDGEM_EV_DEBUG_ACC, `PDGEM_EV_UFP_IND, `PDGEM_EV_FAULT_N};
   int evb[7] = '{9, 14, 11, 16, 12, 13, 10};
   logic [6:0] inv = 7'b1000100;
   int st[4] = '{7, 6, 7, 6};
   int en[4] = '{5, 4, 3, 3};
   always #12.5 clk_in = ~clk_in;
   pdgem_event_mapper uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .port_in(port_in), .in_ev_out(in_ev_out),
      .reject_dr_swap_out(rej), .unlimited_power_flag_out(unlim),
      .source_input_bits0_out(src0), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe_out(gpio_oe_out));
   pdgem_sys_model sys (.gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
      .ext_lvl_in(ext_lvl), .pin_lvl_out(gpio_in));
   // ====
   // tasks
   task chk(input logic c);
      samples_checked++;
      if (c !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH t=%0t in test %s", $time, tname);
      end
   endtask
   task wr(input pdgem_addr_t ad, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= ad;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task rd(input pdgem_addr_t ad, input logic [31:0] x, input logic [31:0] k);
      exp_q.push_back(x);
      msk_q.push_back(k);
      @(posedge clk_in);
      addr_in <= ad;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask
   task pin(input int p, input logic v);
      rd(4'h6, (32'h100 | (32'(v) << 4)) << p, 32'h110 << p);
   endtask
   task pls(input int b);
      @(posedge clk_in);
      port_in[b] <= 1'b1;
      @(posedge clk_in);
      port_in[b] <= 1'b0;
   endtask
   task endt(input string n);
      $display("test %s done", tname);
      tname = n;
   endtask
   task close_out();
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ====
   // monitor
   always @(posedge clk_in) begin
      if (rd_seen) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         chk((rdata_out & m) === e);
      end
      rd_seen = rd_in;
      rise_cnt += int'(in_ev_out.wall_rise === 1'b1);
      fall_cnt += int'(in_ev_out.wall_fall === 1'b1);
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      close_out();
   end
   // ====
   // tests
   initial begin
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      for (int i = 0; i < 10; i++) rd(4'(i), 32'h0, '1);
      wr(4'h6, '1);
      wr(4'h9, '1);
      rd(4'h6, 32'h0, '1);
      rd(4'h9, 32'h0, '1);
      wr(4'h4, 32'h1);
      wr(4'h5, 32'h1);
      rd(4'h4, 32'h1, 32'h1);
      rd(4'h5, 32'h1, 32'h1);
      #1;
      chk(unlim === 1'b1 && src0 === 1'b1);
      wr(4'h4, 32'h0);
      wr(4'h5, 32'h0);
      rd(4'h4, 32'h0, 32'h1);
      #1;
      chk(unlim === 1'b0 && src0 === 1'b0);
      endt("direct");
      for (int k = 0; k < 7; k++) begin
         wr(4'h0, 32'(evs[k]));
         rd(4'h0, 32'(evs[k]), 32'hff);
         repeat (4) begin
            @(posedge clk_in);
            port_in <= pdgem_port_s'(17'($random(seed)) & 17'h1fe00);
            repeat (2) @(posedge clk_in);
            pin(0, port_in[evb[k]] ^ inv[k]);
         end
      end
      endt("liquid");
      wr(4'h1, 32'(`PDGEM_EV_LIQ_NMOS));
      wr(4'h2, 32'(`PDGEM_EV_LIQ_PMOS));
      pin(1, 1'b0);
      pin(2, 1'b0);
      @(posedge clk_in);
      port_in.liquid_running <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      chk(^gpio_out[2:1] === 1'b1 && gpio_oe_out[2:1] === 2'b11);
      a = gpio_out[1];
      repeat (41) @(posedge clk_in);
      #1;
      chk(gpio_out[1] !== a);
      @(posedge clk_in);
      port_in <= '0;
      endt("negotiation");
      wr(4'h3, 32'(`PDGEM_EV_NEG_ACTIVE));
      wr(4'h2, 32'(`PDGEM_EV_SINK_ATTACH));
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_in);
         port_in.is_source <= (s % 2 == 0);
         pls(st[s]);
         repeat (2) @(posedge clk_in);
         pin(3, 1'b1);
         pls(en[s]);
         repeat (2) @(posedge clk_in);
         pin(3, 1'b0);
      end
      endt("sink attach");
      for (int b = 0; b < 4; b++) begin
         @(posedge clk_in);
         port_in.any_port_on_source <= 1'b1;
         repeat (2) @(posedge clk_in);
         pin(2, 1'b1);
         pls(b);
         repeat (2) @(posedge clk_in);
         pin(2, 1'b1);
         @(posedge clk_in);
         port_in.any_port_on_source <= 1'b0;
         repeat (2) @(posedge clk_in);
         pin(2, 1'b1);
         pls(b);
         repeat (2) @(posedge clk_in);
         pin(2, 1'b0);
      end
      endt("inputs");
      for (int i = 0; i < 4; i++) wr(4'(i), 32'h0);
      wr(4'h0, 32'(`PDGEM_EV_WALL_ADP));
      wr(4'h1, 32'(`PDGEM_EV_BLOCK_DRS));
      wr(4'h2, 32'(`PDGEM_EV_CHG_PG_WAIT));
      @(posedge clk_in);
      ext_lvl <= 4'b0111;
      repeat (8) @(posedge clk_in);
      rd(4'h7, 32'h7, 32'h7);
      rd(4'h4, 32'h1, 32'h1);
      rd(4'h5, 32'h1, 32'h1);
      chk(rej === 1'b1 && in_ev_out.charger_power_good_wait === 1'b1);
      @(posedge clk_in);
      ext_lvl <= 4'b0000;
      repeat (8) @(posedge clk_in);
      rd(4'h7, 32'h0, 32'h7);
      rd(4'h4, 32'h0, 32'h1);
      rd(4'h5, 32'h0, 32'h1);
      chk(rej === 1'b0 && rise_cnt == 1 && fall_cnt == 1);
      endt("end");
      close_out();
   end
endmodule
